// >>> inc/uhps_pkg.sv
// constants, states and codes for the host port scheduler
// assumes one 40 MHz clock and plain-port control from software logic
// Behaviour
// - port stays powered off until power bit
// - attach connects; bus reset then enables
// - flag attach and detach events to software
// - reset bit drives bus reset when connected
// - report detected speed in two-bit field
// - limit set: speed from line levels only
// - limit clear: try chirp on bus reset while speed is full
// - suspend when enabled stops sof packets
// - resume bit drives resume signalling while set and suspended
// - remote wakeup while suspended sets wakeup flag
// - default frame timing whenever port enables
// - frame interval sets cycles per frame
// - remaining counter shows low 15 bits of cycles, frozen suspended
// - sof pin pulse of twelve cycles
// - sixteen channels with per-channel settings
// - periodic and non-periodic request queues
// - complete fifo packet makes out request
// - dma mode: enabling in channel makes request
// - periodic queue first, then non-periodic
// - disable entries act at once; fitting ones issue
// - short periodic switches; short non-periodic halts
package uhps_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned FS_FRAME_NS = 1000000;
  localparam int unsigned HS_FRAME_NS = 125000;
  // split the scaling so the 32-bit product cannot overflow
  localparam logic [15:0] FS_FRAME_CYC = 16'(CLK_HZ / 1000 * (FS_FRAME_NS / 1000) / 1000);
  localparam logic [15:0] HS_FRAME_CYC = 16'(CLK_HZ / 1000 * (HS_FRAME_NS / 1000) / 1000);
  localparam logic [3:0] SOF_PULSE_CYC = 4'd12;
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_FS = 2'h1;
  localparam logic [1:0] SPEED_LS = 2'h2;
  localparam int unsigned NUM_CHAN = 16;
  localparam int unsigned QUEUE_DEPTH = 8;
  localparam logic [1:0] XFER_CTRL = 2'h0;
  localparam logic [1:0] XFER_ISO = 2'h1;
  localparam logic [1:0] XFER_BULK = 2'h2;
  localparam logic [1:0] XFER_INTR = 2'h3;
  typedef enum {PORT_OFF, PORT_DISC, PORT_CONN, PORT_RESET, PORT_EN, PORT_SUSP}
    uhps_port_t;
  // queue entry: disable flag, channel, bus time in cycles
  typedef struct packed {
    logic dis;
    logic [3:0] chan;
    logic [14:0] cost;
  } uhps_entry_t;
endpackage

// >>> rtl/uhps_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes async level inputs from the phy side
`timescale 1ns/10ps
module uhps_sync #(parameter int W = 1) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic [W-1:0] din, // async pins
  output logic [W-1:0] dout // filtered level
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change counts only once stages two and three agree
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// >>> rtl/uhps_queue.sv
// small request queue holding scheduler entries
// assumes producer honours ready; consumer pops one entry per cycle
`timescale 1ns/10ps
module uhps_queue
  import uhps_pkg::*;
#(parameter int DEPTH = QUEUE_DEPTH) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic flush, // drop all entries
  input wire logic push, // write entry
  input uhps_pkg::uhps_entry_t push_data, // entry in
  output logic push_ready, // room left
  input wire logic pop, // take head
  output uhps_pkg::uhps_entry_t head, // head entry
  output logic valid // queue not empty
);
  localparam int AW = $clog2(DEPTH);
  uhps_entry_t mem [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  wire do_push = push && push_ready;
  wire do_pop = pop && valid;
  assign push_ready = cnt_reg != (AW+1)'(DEPTH);
  assign valid = cnt_reg != '0;
  assign head = mem[rd_reg];
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_reg] <= push_data;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) wr_reg <= AW'(wr_reg + 1'b1);
      if (do_pop) rd_reg <= AW'(rd_reg + 1'b1);
      cnt_reg <= (AW+1)'(cnt_reg + do_push - do_pop);
    end
  end
endmodule

// >>> rtl/uhps_top.sv
// host port state, speed detection, sof timing and transaction scheduling
// assumes phy line levels arrive unsynchronised; control bits are plain ports
`timescale 1ns/10ps
module uhps_top
  import uhps_pkg::*;
#(parameter int NCH = NUM_CHAN, parameter int DEPTH = QUEUE_DEPTH) (
  input wire logic clk, // 40 mhz clock
  input wire logic srst, // sync reset
  input wire logic port_power_bit, // power the port
  input wire logic port_reset_bit, // hold bus reset while set
  input wire logic port_suspend_bit, // write-one pulse: suspend
  input wire logic port_resume_bit, // hold resume while set
  input wire logic fullspeed_limit_bit, // limit to full/low speed
  input wire logic sof_pulse_out_enable, // enable sof pin pulse
  input wire logic dma_mode, // dma engine makes entries
  input wire logic fri_wr, // pulse: load frame interval
  input wire logic [15:0] frame_interval_field, // cycles per frame
  input wire logic dp_pullup_pin, // dp line high (attach)
  input wire logic dm_pullup_pin, // dm line high (attach)
  input wire logic chirp_k_pin, // device chirp seen
  input wire logic wakeup_pin, // remote wakeup on bus
  input wire logic [NCH-1:0] chan_en, // per-channel enable pulse
  input wire logic [NCH-1:0] chan_in_dir, // 1 = in channel
  input wire logic [NCH*2-1:0] chan_type, // transfer type per channel
  input wire logic [NCH*15-1:0] chan_cost, // bus cycles per transaction
  input wire logic [NCH-1:0] chan_dis_req, // pulse: queue disable
  input wire logic [NCH-1:0] pkt_written, // pulse: full packet in fifo
  input wire logic conn_flag_clr, // clear connect flag
  input wire logic disc_flag_clr, // clear disconnect flag
  input wire logic wakeup_flag_clr, // clear wakeup flag
  input wire logic sie_done, // serial engine finished
  output logic phy_power, // phy power on
  output logic bus_reset_drive, // driving se0 reset
  output logic resume_drive, // driving resume k
  output logic chirp_active, // chirp attempt running
  output logic [1:0] port_speed_field, // detected speed
  output logic port_connected, // port connected or above
  output logic port_enabled, // port enabled
  output logic port_suspended, // port suspended
  output logic conn_flag, // sticky attach flag
  output logic disc_flag, // sticky detach flag
  output logic wakeup_flag, // sticky remote wakeup flag
  output logic wakeup_irq, // wakeup interrupt
  output logic [14:0] frame_remaining_field, // low 15 bits of cycles left in frame
  output logic sof_send, // pulse: send sof token
  output logic sof_pin, // sof pulse output
  output logic sie_start, // pulse: start transaction
  output logic [3:0] sie_chan, // channel of transaction
  output logic [NCH-1:0] chan_active // channel enabled state
);
  import uhps_pkg::*;

  uhps_port_t st_reg, st_next;
  logic [3:0] pins_s;
  logic dp_s, dm_s, chirp_s, wake_s;
  logic [1:0] speed_reg;
  logic [15:0] fri_reg;
  logic [15:0] cnt_reg;
  logic [3:0] sofp_reg;
  logic busy_reg, np_halt_reg, rst_prev_reg;
  logic [NCH-1:0] chan_reg;

  uhps_sync #(.W(4)) u_sync (
    .clk(clk),
    .srst(srst),
    .din({dp_pullup_pin, dm_pullup_pin, chirp_k_pin, wakeup_pin}),
    .dout(pins_s)
  );
  assign {dp_s, dm_s, chirp_s, wake_s} = pins_s;

  wire attached = dp_s || dm_s;
  wire live = st_reg == PORT_CONN || st_reg == PORT_RESET || st_reg == PORT_EN
    || st_reg == PORT_SUSP;
  wire detach = live && !attached;
  wire attach_ev = st_reg == PORT_DISC && attached;
  wire reset_end = st_reg == PORT_RESET && !port_reset_bit;

  // port state machine
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PORT_OFF: if (port_power_bit) st_next = PORT_DISC;
      PORT_DISC: if (attached) st_next = PORT_CONN;
      PORT_CONN: if (port_reset_bit) st_next = PORT_RESET;
      PORT_RESET: if (!port_reset_bit) st_next = PORT_EN;
      PORT_EN: begin
        if (port_reset_bit) st_next = PORT_RESET;
        else if (port_suspend_bit) st_next = PORT_SUSP;
      end
      PORT_SUSP: if (port_reset_bit) st_next = PORT_RESET;
      default: st_next = PORT_OFF;
    endcase
    if (detach) st_next = PORT_DISC;
    if (!port_power_bit) st_next = PORT_OFF;
  end

  // speed: line levels at attach, chirp during reset if not limited
  function automatic logic [1:0] line_speed(input logic dp, input logic dm);
    line_speed = (dm && !dp) ? SPEED_LS : SPEED_FS;
  endfunction
  logic [1:0] speed_next;
  always_comb begin
    speed_next = speed_reg;
    if (attach_ev) speed_next = line_speed(dp_s, dm_s);
    else if (st_reg == PORT_RESET && !fullspeed_limit_bit && speed_reg == SPEED_FS
      && chirp_s) speed_next = SPEED_HS;
  end

  // frame counter; default interval reloaded on each enable
  wire entering_en = st_next == PORT_EN && st_reg != PORT_EN && st_reg != PORT_SUSP;
  wire [15:0] dflt_fri = (speed_next == SPEED_HS) ? HS_FRAME_CYC : FS_FRAME_CYC;
  wire running = st_reg == PORT_EN;
  wire frame_end = running && cnt_reg <= 16'h0001;
  wire [15:0] cnt_next = !running ? cnt_reg : frame_end ? fri_reg : 16'(cnt_reg - 1'b1);

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= PORT_OFF;
      speed_reg <= SPEED_FS;
      fri_reg <= FS_FRAME_CYC;
      cnt_reg <= FS_FRAME_CYC;
      rst_prev_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      speed_reg <= speed_next;
      rst_prev_reg <= port_reset_bit;
      if (entering_en) begin
        fri_reg <= dflt_fri;
        cnt_reg <= dflt_fri;
      end else begin
        if (fri_wr) fri_reg <= frame_interval_field;
        cnt_reg <= cnt_next;
      end
    end
  end

  // status outputs and sticky flags, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      phy_power <= 1'b0;
      bus_reset_drive <= 1'b0;
      resume_drive <= 1'b0;
      chirp_active <= 1'b0;
      port_speed_field <= SPEED_FS;
      port_connected <= 1'b0;
      port_enabled <= 1'b0;
      port_suspended <= 1'b0;
      conn_flag <= 1'b0;
      disc_flag <= 1'b0;
      wakeup_flag <= 1'b0;
      wakeup_irq <= 1'b0;
      frame_remaining_field <= '0;
    end else begin
      phy_power <= st_next != PORT_OFF;
      bus_reset_drive <= st_next == PORT_RESET;
      resume_drive <= st_next == PORT_SUSP && port_resume_bit;
      chirp_active <= st_next == PORT_RESET && !fullspeed_limit_bit
        && speed_next == SPEED_FS;
      port_speed_field <= speed_next;
      port_connected <= st_next != PORT_OFF && st_next != PORT_DISC;
      port_enabled <= st_next == PORT_EN;
      port_suspended <= st_next == PORT_SUSP;
      conn_flag <= attach_ev || (conn_flag && !conn_flag_clr);
      disc_flag <= detach || (disc_flag && !disc_flag_clr);
      wakeup_flag <= (st_reg == PORT_SUSP && wake_s)
        || (wakeup_flag && !wakeup_flag_clr);
      wakeup_irq <= (st_reg == PORT_SUSP && wake_s)
        || (wakeup_flag && !wakeup_flag_clr);
      frame_remaining_field <= entering_en ? dflt_fri[14:0] : cnt_next[14:0];
    end
  end

  // sof token and twelve-cycle pin pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      sof_send <= 1'b0;
      sof_pin <= 1'b0;
      sofp_reg <= '0;
    end else begin
      sof_send <= frame_end && st_next == PORT_EN;
      if (frame_end && st_next == PORT_EN && sof_pulse_out_enable) begin
        sofp_reg <= SOF_PULSE_CYC;
      end else if (sofp_reg != '0) begin
        sofp_reg <= 4'(sofp_reg - 1'b1);
      end
      sof_pin <= (frame_end && st_next == PORT_EN && sof_pulse_out_enable)
        || sofp_reg > 4'h1;
    end
  end

  // entry creation: one request per cycle, lowest channel first
  function automatic logic is_periodic(input logic [1:0] t);
    is_periodic = t == XFER_ISO || t == XFER_INTR;
  endfunction
  logic [NCH-1:0] req_vec;
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] dis_pend_reg;
  logic pick_ok, pick_dis;
  logic [3:0] pick;
  always_comb begin
    pick_ok = 1'b0;
    pick_dis = 1'b0;
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (dis_pend_reg[i] || pend_reg[i]) begin
        pick_ok = 1'b1;
        pick_dis = dis_pend_reg[i];
        pick = 4'(i);
      end
    end
  end
  // out after full fifo packet, in on enable in dma mode
  assign req_vec = pkt_written | (chan_en & chan_in_dir & {NCH{dma_mode}});
  wire pick_per = is_periodic(chan_type[pick*2 +: 2]);
  uhps_entry_t new_e;
  assign new_e = '{dis: pick_dis, chan: pick, cost: chan_cost[pick*15 +: 15]};
  logic pq_rdy, nq_rdy, pq_v, nq_v, pq_pop, nq_pop;
  uhps_entry_t pq_h, nq_h;
  wire push_ok = pick_per ? pq_rdy : nq_rdy;
  wire take = pick_ok && push_ok;
  wire flush = !live;

  uhps_queue #(.DEPTH(DEPTH)) u_pq (
    .clk(clk), .srst(srst), .flush(flush), .push(take && pick_per), .push_data(new_e),
    .push_ready(pq_rdy), .pop(pq_pop), .head(pq_h), .valid(pq_v));
  uhps_queue #(.DEPTH(DEPTH)) u_nq (
    .clk(clk), .srst(srst), .flush(flush), .push(take && !pick_per), .push_data(new_e),
    .push_ready(nq_rdy), .pop(nq_pop), .head(nq_h), .valid(nq_v));

  // scheduler: periodic first, non-periodic halts until frame end
  // full-speed frames exceed 15 bits; saturate rather than wrap
  wire [14:0] left = (cnt_reg > 16'h7fff) ? 15'h7fff : cnt_reg[14:0];
  wire pq_fit = pq_h.dis || pq_h.cost < left;
  wire nq_fit = nq_h.dis || nq_h.cost < left;
  wire sched_ok = running && !busy_reg && !frame_end;
  assign pq_pop = sched_ok && pq_v && pq_fit;
  assign nq_pop = sched_ok && !np_halt_reg && !(pq_v && pq_fit) && nq_v && nq_fit;
  wire issue_p = pq_pop && !pq_h.dis;
  wire issue_n = nq_pop && !nq_h.dis;

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_reg <= '0;
      dis_pend_reg <= '0;
      chan_reg <= '0;
      busy_reg <= 1'b0;
      np_halt_reg <= 1'b0;
      sie_start <= 1'b0;
      sie_chan <= '0;
      chan_active <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pend_reg[i] <= req_vec[i] || (pend_reg[i] && !(take && !pick_dis && pick == 4'(i)));
        dis_pend_reg[i] <= chan_dis_req[i] || (dis_pend_reg[i] && !(take && pick_dis
          && pick == 4'(i)));
      end
      chan_reg <= (chan_reg | chan_en);
      if (pq_pop && pq_h.dis) chan_reg[pq_h.chan] <= 1'b0;
      if (nq_pop && nq_h.dis) chan_reg[nq_h.chan] <= 1'b0;
      if (!live) chan_reg <= '0;
      np_halt_reg <= frame_end || !running ? 1'b0
        : (np_halt_reg || (sched_ok && !(pq_v && pq_fit) && nq_v && !nq_fit));
      busy_reg <= running && (issue_p || issue_n || (busy_reg && !sie_done));
      sie_start <= issue_p || issue_n;
      if (issue_p || issue_n) sie_chan <= issue_p ? pq_h.chan : nq_h.chan;
      chan_active <= chan_reg;
    end
  end

  sof_width_a: assert property (@(posedge clk) disable iff (srst)
    $rose(sof_pin) |-> sof_pin [*8] ##1 sof_pin [*4] ##1 !sof_pin)
    else $error("sof pulse not twelve cycles");
  off_stay_a: assert property (@(posedge clk) disable iff (srst)
    !port_power_bit |=> !phy_power)
    else $error("phy powered without power bit");
  susp_nosof_a: assert property (@(posedge clk) disable iff (srst)
    port_suspended |-> !sof_send)
    else $error("sof sent while suspended");
  frt_freeze_a: assert property (@(posedge clk) disable iff (srst)
    port_suspended && $past(port_suspended) |-> $stable(frame_remaining_field))
    else $error("remaining count moved in suspend");
  rst_drive_a: assert property (@(posedge clk) disable iff (srst)
    bus_reset_drive |-> $past(port_reset_bit))
    else $error("bus reset without reset bit");
  disc_flag_a: assert property (@(posedge clk) disable iff (srst)
    detach |=> disc_flag)
    else $error("detach not flagged");
  wake_flag_a: assert property (@(posedge clk) disable iff (srst)
    st_reg == PORT_SUSP && wake_s |=> wakeup_flag && wakeup_irq)
    else $error("wakeup not flagged");
  np_halt_a: assert property (@(posedge clk) disable iff (srst)
    np_halt_reg |-> !nq_pop)
    else $error("non-periodic served while halted");
  dis_chan_a: assert property (@(posedge clk) disable iff (srst)
    pq_pop && pq_h.dis && !chan_en[pq_h.chan] |=> !chan_reg[$past(pq_h.chan)])
    else $error("disable entry did not clear channel");
  en_default_a: assert property (@(posedge clk) disable iff (srst)
    entering_en && speed_next == SPEED_HS |=> fri_reg == HS_FRAME_CYC)
    else $error("default hs interval not loaded");
  resume_a: assert property (@(posedge clk) disable iff (srst)
    resume_drive |-> port_suspended && $past(port_resume_bit))
    else $error("resume driven wrongly");
endmodule

// >>> dv/uhps_dev_model.sv
// attached usb device: line pull-ups, chirp reply to bus reset, remote wakeup
// assumes host outputs are sampled on the system clock
`timescale 1ns/10ps
module uhps_dev_model (
  input wire logic clk, // system clock
  input wire logic attach, // device plugged in
  input wire logic low_speed, // low-speed device
  input wire logic hs_capable, // answers a chirp
  input wire logic wake_req, // start remote wakeup
  input wire logic bus_reset_drive, // host se0 reset
  input wire logic port_suspended, // host port suspended
  output logic dp_pullup_pin, // dp level
  output logic dm_pullup_pin, // dm level
  output logic chirp_k_pin, // chirp k level
  output logic wakeup_pin // resume k level
);
  logic [3:0] rst_cnt = 4'h0;
  logic [2:0] wake_cnt = 3'h0;
  // host pull-downs take a released line low
  assign dp_pullup_pin = attach & ~low_speed;
  assign dm_pullup_pin = attach & low_speed;
  // chirp only once the reset has lasted a while
  assign chirp_k_pin = attach & hs_capable & (rst_cnt == 4'hf);
  assign wakeup_pin = wake_cnt != 3'h0;
  always @(posedge clk) begin
    if (!bus_reset_drive) rst_cnt <= 4'h0;
    else if (rst_cnt != 4'hf) rst_cnt <= rst_cnt + 4'h1;
    // wakeup only makes sense toward a suspended host
    if (wake_req && port_suspended && wake_cnt == 3'h0) wake_cnt <= 3'h6;
    else if (wake_cnt != 3'h0) wake_cnt <= wake_cnt - 3'h1;
  end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the host port scheduler
// assumes a 40 mhz clock and the device model on the bus pins
`timescale 1ns/10ps
module testbench;
  import uhps_pkg::*;
  logic clk = 0, srst = 1, port_power_bit = 0, port_reset_bit = 0, port_suspend_bit = 0;
  logic port_resume_bit = 0, fullspeed_limit_bit = 0, sof_pulse_out_enable = 0, dma_mode = 0;
  logic fri_wr = 0, conn_flag_clr = 0, disc_flag_clr = 0, wakeup_flag_clr = 0, sie_done = 0;
  logic attach = 0, low_speed = 0, hs_capable = 1, wake_req = 0;
  logic [15:0] frame_interval_field = 16'h0;
  logic [15:0] chan_en = 16'h0, chan_in_dir = 16'h0, chan_dis_req = 16'h0, pkt_written = 16'h0;
  logic [31:0] chan_type = 32'h0;
  logic [239:0] chan_cost = 240'h0;
  logic dp_pullup_pin, dm_pullup_pin, chirp_k_pin, wakeup_pin, phy_power, bus_reset_drive;
  logic resume_drive, chirp_active, port_connected, port_enabled, port_suspended, conn_flag;
  logic disc_flag, wakeup_flag, wakeup_irq, sof_send, sof_pin, sie_start;
  logic [1:0] port_speed_field;
  logic [14:0] frame_remaining_field;
  logic [3:0] sie_chan;
  logic [15:0] chan_active;
  int error_cnt = 0, samples_checked = 0;

  always #12.5 clk = ~clk; // one 40 mhz clock stands in for the usb clock

  uhps_top #(.NCH(NUM_CHAN), .DEPTH(QUEUE_DEPTH)) i_dut (
    .clk, .srst, .port_power_bit, .port_reset_bit, .port_suspend_bit, .port_resume_bit,
    .fullspeed_limit_bit, .sof_pulse_out_enable, .dma_mode, .fri_wr, .frame_interval_field,
    .dp_pullup_pin, .dm_pullup_pin, .chirp_k_pin, .wakeup_pin, .chan_en, .chan_in_dir,
    .chan_type, .chan_cost, .chan_dis_req, .pkt_written, .conn_flag_clr, .disc_flag_clr,
    .wakeup_flag_clr, .sie_done, .phy_power, .bus_reset_drive, .resume_drive, .chirp_active,
    .port_speed_field, .port_connected, .port_enabled, .port_suspended, .conn_flag, .disc_flag,
    .wakeup_flag, .wakeup_irq, .frame_remaining_field, .sof_send, .sof_pin, .sie_start,
    .sie_chan, .chan_active);

  uhps_dev_model i_dev (.clk, .attach, .low_speed, .hs_capable, .wake_req, .bus_reset_drive,
    .port_suspended, .dp_pullup_pin, .dm_pullup_pin, .chirp_k_pin, .wakeup_pin);

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp_v, input logic [15:0] got_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp_v, got_v);
    end
  endtask

  task give_verdict;
    $display("checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // serial engine stand-in: each started transaction ends five cycles later
  always begin
    step(1);
    if (sie_start === 1'b1) begin
      step(4);
      sie_done = 1;
      step(1);
      sie_done = 0;
    end
  end

  task automatic expect_start(input logic [3:0] ch);
    int n;
    step(1);
    for (n = 0; n < 700 && sie_start !== 1'b1; n++) step(1);
    chk("sie_start", 16'h1, 16'(sie_start));
    chk("sie_chan", 16'(ch), 16'(sie_chan));
  endtask

  task automatic t_power;
    port_reset_bit = 1;
    attach = 1;
    step(10);
    chk("bus_reset_drive", 16'h0, 16'(bus_reset_drive));
    chk("phy_power", 16'h0, 16'(phy_power));
    chk("port_connected", 16'h0, 16'(port_connected));
    port_reset_bit = 0;
    port_power_bit = 1;
    step(2);
    chk("phy_power", 16'h1, 16'(phy_power));
  endtask

  task automatic t_hs_connect;
    int n;
    for (n = 0; n < 20 && conn_flag !== 1'b1; n++) step(1);
    chk("conn_flag", 16'h1, 16'(conn_flag));
    chk("port_connected", 16'h1, 16'(port_connected));
    chk("port_speed_field", 16'(SPEED_FS), 16'(port_speed_field));
    conn_flag_clr = 1;
    port_reset_bit = 1;
    step(1);
    conn_flag_clr = 0;
    step(2);
    chk("bus_reset_drive", 16'h1, 16'(bus_reset_drive));
    chk("chirp_active", 16'h1, 16'(chirp_active));
    step(30);
    chk("port_enabled", 16'h0, 16'(port_enabled));
    port_reset_bit = 0;
    for (n = 0; n < 10 && port_enabled !== 1'b1; n++) step(1);
    chk("bus_reset_drive", 16'h0, 16'(bus_reset_drive));
    chk("port_speed_field", 16'(SPEED_HS), 16'(port_speed_field));
    chk("conn_flag", 16'h0, 16'(conn_flag));
    for (n = 0; n < 6000 && sof_send !== 1'b1; n++) step(1);
    chk("hs frame length", 16'h1, 16'(n > 4990 && n < 5005));
  endtask

  task automatic t_frames;
    int n;
    frame_interval_field = 16'd300;
    fri_wr = 1;
    sof_pulse_out_enable = 1;
    step(1);
    fri_wr = 0;
    // the new interval only takes hold at the next frame boundary
    for (n = 0; n < 6000 && sof_send !== 1'b1; n++) step(1);
    for (n = 1; n < 400; n++) begin
      step(1);
      if (sof_send === 1'b1) break;
    end
    chk("frame length", 16'd300, 16'(n));
    for (n = 0; n < 5 && sof_pin !== 1'b1; n++) step(1);
    for (n = 0; n < 20 && sof_pin === 1'b1; n++) step(1);
    chk("sof_pin cycles", 16'(SOF_PULSE_CYC), 16'(n));
  endtask

  task automatic t_sched;
    int n;
    pkt_written = 16'h0006;
    step(1);
    pkt_written = 16'h0;
    expect_start(4'h1);
    expect_start(4'h2);
    dma_mode = 1;
    chan_in_dir = 16'h0020;
    chan_en = 16'h0020;
    step(1);
    chan_en = 16'h0;
    step(2);
    chk("chan_active", 16'h0020, chan_active);
    expect_start(4'h5);
    chan_dis_req = 16'h0020;
    step(1);
    chan_dis_req = 16'h0;
    step(6);
    chk("chan_active", 16'h0, chan_active);
    pkt_written = 16'h0008;
    step(1);
    pkt_written = 16'h0002;
    step(1);
    pkt_written = 16'h0;
    expect_start(4'h1);
    pkt_written = 16'h0010;
    step(1);
    pkt_written = 16'h0002;
    step(1);
    pkt_written = 16'h0;
    for (n = 0; n < 700 && sie_start !== 1'b1; n++) step(1);
    chk("sie_start", 16'h0, 16'(sie_start));
  endtask

  task automatic t_suspend;
    int n;
    logic [14:0] held;
    port_suspend_bit = 1;
    step(1);
    port_suspend_bit = 0;
    step(2);
    held = frame_remaining_field;
    chk("port_suspended", 16'h1, 16'(port_suspended));
    for (n = 0; n < 400 && sof_send !== 1'b1; n++) step(1);
    chk("sof_send", 16'h0, 16'(sof_send));
    chk("frame_remaining", 16'(held), 16'(frame_remaining_field));
    wake_req = 1;
    step(1);
    wake_req = 0;
    for (n = 0; n < 40 && wakeup_flag !== 1'b1; n++) step(1);
    chk("wakeup_flag", 16'h1, 16'(wakeup_flag));
    chk("wakeup_irq", 16'h1, 16'(wakeup_irq));
    port_resume_bit = 1;
    step(12);
    chk("resume_drive", 16'h1, 16'(resume_drive));
    port_resume_bit = 0;
    wakeup_flag_clr = 1;
    step(1);
    wakeup_flag_clr = 0;
    step(2);
    chk("resume_drive", 16'h0, 16'(resume_drive));
    chk("wakeup_flag", 16'h0, 16'(wakeup_flag));
  endtask

  task automatic t_detach;
    int n;
    attach = 0;
    for (n = 0; n < 20 && disc_flag !== 1'b1; n++) step(1);
    chk("disc_flag", 16'h1, 16'(disc_flag));
    chk("port_connected", 16'h0, 16'(port_connected));
    chk("port_enabled", 16'h0, 16'(port_enabled | port_suspended));
    for (n = 0; n < 400 && sof_send !== 1'b1; n++) step(1);
    chk("sof_send", 16'h0, 16'(sof_send));
    disc_flag_clr = 1;
    step(1);
    disc_flag_clr = 0;
  endtask

  task automatic t_fs_limit;
    int n;
    fullspeed_limit_bit = 1;
    low_speed = 1;
    attach = 1;
    for (n = 0; n < 20 && port_connected !== 1'b1; n++) step(1);
    step(2);
    chk("port_speed_field", 16'(SPEED_LS), 16'(port_speed_field));
    t_detach();
    low_speed = 0;
    attach = 1;
    for (n = 0; n < 20 && port_connected !== 1'b1; n++) step(1);
    port_reset_bit = 1;
    step(30);
    chk("chirp_active", 16'h0, 16'(chirp_active));
    port_reset_bit = 0;
    for (n = 0; n < 10 && port_enabled !== 1'b1; n++) step(1);
    chk("port_speed_field", 16'(SPEED_FS), 16'(port_speed_field));
    for (n = 0; n < 41000 && sof_send !== 1'b1; n++) step(1);
    chk("fs frame length", 16'h1, 16'(n > 39990 && n < 40005));
  endtask

  initial begin
    chan_type[3:2] = XFER_BULK;
    chan_type[5:4] = XFER_INTR;
    chan_type[7:6] = XFER_ISO;
    chan_type[9:8] = XFER_BULK;
    chan_cost[15 +: 15] = 15'd20;
    chan_cost[30 +: 15] = 15'd20;
    chan_cost[45 +: 15] = 15'd400;
    chan_cost[60 +: 15] = 15'd400;
    chan_cost[75 +: 15] = 15'd20;
    step(2);
    srst = 0;
    t_power();
    t_hs_connect();
    t_frames();
    t_sched();
    t_suspend();
    t_detach();
    t_fs_limit();
    give_verdict();
  end

  // about 55k cycles expected; cut a hang well beyond that
  initial begin
    #(90000 * 25);
    error_cnt++;
    give_verdict();
  end
endmodule
